// *** design/ars_pkg.sv ***
// shared constants and types for the atomic store decorator
package ars_pkg;

   // ======================================================
   // address fields of a decorated store
   localparam int unsigned OFFSET_MSB  = 19;
   localparam int unsigned FUNC_MSB    = 28;
   localparam int unsigned FUNC_LSB    = 26;
   localparam int unsigned TARGET_MSB  = 30;
   localparam int unsigned TARGET_LSB  = 29;
   localparam int unsigned TOP_BIT     = 31;

   localparam logic [1:0] TARGET_RAM   = 2'h1;
   localparam logic [1:0] TARGET_PERI  = 2'h2;
   localparam logic [2:0] FUNC_AND     = 3'h1;
   localparam logic [2:0] FUNC_OR      = 3'h2;
   localparam logic [2:0] FUNC_XOR     = 3'h3;

   // real bases the offset is added to
   localparam logic [31:0] RAM_BASE    = 32'h2000_0000;
   localparam logic [31:0] PERI_BASE   = 32'h4000_0000;

   // ======================================================
   // bus encodings and reset values
   localparam logic [1:0]  HTRANS_IDLE = 2'h0;
   localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
   localparam logic        HRESP_OKAY  = 1'h0;
   localparam logic [31:0] DATA_RST    = 32'h0000_0000;

   typedef enum logic [1:0] {FN_AND, FN_OR, FN_XOR} ars_func_e;
   typedef enum logic [1:0] {ST_PASS, ST_RMW_READ, ST_RMW_WRITE} ars_state_e;

   // address phase of one transfer
   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [2:0]  hburst;
      logic [3:0]  hprot;
      logic        hmastlock;
   } ars_req_s;

   localparam ars_req_s REQ_RST = '0;

   // result of decoding one address phase
   typedef struct packed {
      logic        hit;
      ars_func_e   func;
      logic [31:0] target;
   } ars_dec_s;

endpackage

// *** design/ars_decode.sv ***
// address decoder for decorated stores
`timescale 1ns/1ps
module ars_decode
   import ars_pkg::*;
#(
   parameter logic [3:0] CORE_MASTER_ID = 4'h0
) (
   input  wire ars_req_s   req,
   input  wire logic [3:0] masterId,
   output      ars_dec_s   dec
);

   // ======================================================
   // field decode; bits 25..20 are never looked at
   // [RULE_21] don't-care bits unread
   wire [1:0]  tgtSel  = req.haddr[TARGET_MSB:TARGET_LSB];
   wire [2:0]  funcSel = req.haddr[FUNC_MSB:FUNC_LSB];
   // [RULE_01] core transfers only
   wire        isCore  = (masterId == CORE_MASTER_ID);
   wire        isRam   = (tgtSel == TARGET_RAM);
   wire        isPeri  = (tgtSel == TARGET_PERI);
   wire        isFunc  = (funcSel == FUNC_AND) || (funcSel == FUNC_OR) || (funcSel == FUNC_XOR);
   wire        isStore = req.htrans[1] && req.hwrite && !req.haddr[TOP_BIT];
   wire [31:0] base    = isRam ? RAM_BASE : PERI_BASE;
   // [RULE_20] twenty-bit offset
   wire [31:0] offset  = {12'h000, req.haddr[OFFSET_MSB:0]};

   // other masters never get decoration, plain access instead
   assign dec.hit    = isCore && isStore && (isRam || isPeri) && isFunc;
   assign dec.func   = (funcSel == FUNC_AND) ? FN_AND : ((funcSel == FUNC_OR) ? FN_OR : FN_XOR);
   // decoration bits 28..20 drop out of the real address
   // [RULE_06] [RULE_23] base plus offset
   assign dec.target = base | offset;

endmodule

// *** design/ars_alu.sv ***
// modify step of the read-modify-write
`timescale 1ns/1ps
module ars_alu
   import ars_pkg::*;
#(
   parameter int unsigned WIDTH = 32
) (
   input  wire ars_func_e        func,
   input  wire logic [WIDTH-1:0] rdata,
   input  wire logic [WIDTH-1:0] wdata,
   output      logic [WIDTH-1:0] result
);

   // ======================================================
   // full-width op; lane replication by the core makes it size-safe
   wire [WIDTH-1:0] andVal = rdata & wdata;
   wire [WIDTH-1:0] orVal  = rdata | wdata;
   wire [WIDTH-1:0] xorVal = rdata ^ wdata;

   assign result = (func == FN_AND) ? andVal : ((func == FN_OR) ? orVal : xorVal);

endmodule

// *** design/ars_decorator.sv ***
// bus stage turning decorated stores into locked read-modify-writes
// Notes on behaviour
// [RULE_01] only the core's transfers may be decorated; others pass plain
// [RULE_02] two stages, address and data, with bus timing on both sides
// [RULE_03] undecorated transfers pass through combinationally, no added cycles
// [RULE_04] decorated peripheral window maps onto plain peripheral space
// [RULE_05] decorated ram window maps onto upper ram
// [RULE_06] peripheral target spans 512 KB block plus 4 KB port block
// [RULE_07] no software registers; behaviour chosen by address only
// [RULE_08] no modes; each access handled by its address alone
// [RULE_09] one clock domain for all logic and ports
// [RULE_10] decorated store becomes indivisible 2-cycle read then write
// [RULE_11] first address phase: read at stripped address, capture address
// [RULE_12] next cycle: write address phase reusing captured address
// [RULE_13] first data phase: combine read and write data, stall master
// [RULE_14] second data phase: drive registered result as write data
// [RULE_15] slave wait states pass back to master cycle for cycle
// [RULE_16] operand size follows the write transfer size
// [RULE_17] master replicates byte and halfword data across lanes
// [RULE_18] bits 30..29: 01 selects ram, 10 selects peripherals
// [RULE_19] function 001 writes back read AND write data
// [RULE_20] low twenty address bits are the offset from region base
// [RULE_21] don't-care address bits are ignored
// [RULE_22] keep output bus toggling low
// [RULE_23] bits 28..20 carry decoration and are stripped
// [RULE_24] function 010 writes back read OR write data
// [RULE_25] function 011 writes back read XOR write data
// [RULE_26] nothing may come between the read and the write
`timescale 1ns/1ps
module ars_decorator
   import ars_pkg::*;
#(
   parameter logic [3:0] CORE_MASTER_ID = 4'h0
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire ars_req_s    mstReq,
   input  wire logic [31:0] mstWdata,
   input  wire logic [3:0]  mstMasterId,
   output      logic [31:0] mstRdata,
   output      logic        mstReady,
   output      logic        mstResp,
   output      ars_req_s    slvReq,
   output      logic [31:0] slvWdata,
   input  wire logic [31:0] slvRdata,
   input  wire logic        slvReady,
   input  wire logic        slvResp
);

   // ======================================================
   // state
   ars_state_e  stateReg;
   ars_state_e  stateNext;
   ars_req_s    capReg;
   ars_func_e   funcReg;
   logic [31:0] modReg;
   ars_dec_s    dec;
   logic [31:0] aluOut;

   // ======================================================
   // address decode, one clock domain so nothing is synchronised
   // [RULE_07] [RULE_08] address alone decides
   // [RULE_04] [RULE_05] [RULE_18] window and target select
   ars_decode #(
      .CORE_MASTER_ID (CORE_MASTER_ID)
   ) u_decode (
      .req      (mstReq),
      .masterId (mstMasterId),
      .dec      (dec)
   );

   // modify data with the function captured at the read
   ars_alu #(
      .WIDTH (32)
   ) u_alu (
      .func   (funcReg),
      .rdata  (slvRdata),
      .wdata  (mstWdata),
      .result (aluOut)
   );

   // ======================================================
   // phase selects
   wire inRead  = (stateReg == ST_RMW_READ);
   wire inWrite = (stateReg == ST_RMW_WRITE);
   // a decorated address phase starts in any cycle outside the read phase
   wire decStart = dec.hit && !inRead;
   wire capture  = decStart && slvReady;
   wire modTake  = inRead && slvReady;

   // [RULE_11] read at stripped address, locked
   ars_req_s readReq;
   assign readReq.haddr     = dec.target;
   assign readReq.htrans    = HTRANS_NSEQ;
   assign readReq.hwrite    = 1'b0;
   assign readReq.hsize     = mstReq.hsize;
   assign readReq.hburst    = mstReq.hburst;
   assign readReq.hprot     = mstReq.hprot;
   assign readReq.hmastlock = 1'b1;

   // [RULE_12] recirculated write, same address and size
   ars_req_s writeReq;
   assign writeReq.haddr     = capReg.haddr;
   assign writeReq.htrans    = HTRANS_NSEQ;
   assign writeReq.hwrite    = 1'b1;
   assign writeReq.hsize     = capReg.hsize;
   assign writeReq.hburst    = capReg.hburst;
   assign writeReq.hprot     = capReg.hprot;
   assign writeReq.hmastlock = 1'b1;

   // ======================================================
   // output side
   // [RULE_03] plain transfers go straight through
   // [RULE_26] the write phase sits right behind the read
   assign slvReq = inRead ? writeReq : (decStart ? readReq : mstReq);

   // [RULE_14] registered result on write data phase
   // [RULE_22] held during the read phase too, so lines stay quiet
   assign slvWdata = (inRead || inWrite) ? modReg : mstWdata;

   // ======================================================
   // master side
   // [RULE_13] stall the master through the read data phase
   // [RULE_15] otherwise the slave's waits pass straight back
   assign mstReady = inRead ? 1'b0 : slvReady;
   assign mstResp  = inRead ? HRESP_OKAY : slvResp;
   assign mstRdata = slvRdata;

   // ======================================================
   // sequencer
   // [RULE_10] read phase then write phase, then back to pass, or straight into the next read phase when a decorated store follows
   always_comb begin
      stateNext = stateReg;
      unique case (stateReg)
         ST_PASS, ST_RMW_WRITE: begin
            if (slvReady) begin
               stateNext = decStart ? ST_RMW_READ : ST_PASS;
            end
         end
         ST_RMW_READ: begin
            if (slvReady) begin
               stateNext = ST_RMW_WRITE;
            end
         end
      endcase
   end

   // [RULE_02] stage registers between the two phases
   // [RULE_09] one clock, no crossings
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stateReg <= ST_PASS;
      end else begin
         stateReg <= stateNext;
      end
   end

   // capture real address and attributes of the decorated store
   // [RULE_16] size carried into the write
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         capReg  <= REQ_RST;
         funcReg <= FN_AND;
      end else if (capture) begin
         capReg  <= readReq;
         funcReg <= dec.func;
      end
   end

   // [RULE_19] [RULE_24] [RULE_25] result register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         modReg <= DATA_RST;
      end else if (modTake) begin
         modReg <= aluOut;
      end
   end

   // ======================================================
   // checks
   logic [31:0] rdPast;
   logic [31:0] wdPast;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdPast <= DATA_RST;
         wdPast <= DATA_RST;
      end else begin
         rdPast <= slvRdata;
         wdPast <= mstWdata;
      end
   end

   sequence s_start;
      decStart && slvReady;
   endsequence

   sequence s_readAddr;
      !slvReq.hwrite && slvReq.hmastlock && (slvReq.htrans == HTRANS_NSEQ);
   endsequence

   property p_readFirst;
      @(posedge core_clk) disable iff (rst)
      s_start |-> s_readAddr ##1 (inRead && slvReq.hwrite);
   endproperty
   a_readFirst: assert property (p_readFirst) else $error("decorated store did not read first"); // [RULE_11]

   property p_strip;
      @(posedge core_clk) disable iff (rst)
      decStart |-> (slvReq.haddr[19:0] == mstReq.haddr[19:0]) && (slvReq.haddr[28:20] == 9'h000);
   endproperty
   a_strip: assert property (p_strip) else $error("decoration not stripped"); // [RULE_23]

   property p_recirc;
      @(posedge core_clk) disable iff (rst)
      s_start |=> (slvReq.haddr == $past(slvReq.haddr)) && (slvReq.hsize == $past(mstReq.hsize));
   endproperty
   a_recirc: assert property (p_recirc) else $error("write phase lost the read address"); // [RULE_12]

   property p_stall;
      @(posedge core_clk) disable iff (rst)
      inRead |-> !mstReady && slvReq.hmastlock;
   endproperty
   a_stall: assert property (p_stall) else $error("master not stalled in read phase"); // [RULE_13]

   property p_seqDone;
      @(posedge core_clk) disable iff (rst)
      s_start |=> inRead [*1] ##[0:63] (inWrite && (slvWdata == modReg));
   endproperty
   a_seqDone: assert property (p_seqDone) else $error("write phase missing"); // [RULE_10]

   property p_andOp;
      @(posedge core_clk) disable iff (rst)
      (modTake && funcReg == FN_AND) |=> (slvWdata == (rdPast & wdPast));
   endproperty
   a_andOp: assert property (p_andOp) else $error("and result wrong"); // [RULE_19]

   property p_orOp;
      @(posedge core_clk) disable iff (rst)
      (modTake && funcReg == FN_OR) |=> (slvWdata == (rdPast | wdPast));
   endproperty
   a_orOp: assert property (p_orOp) else $error("or result wrong"); // [RULE_24]

   property p_xorOp;
      @(posedge core_clk) disable iff (rst)
      (modTake && funcReg == FN_XOR) |=> (slvWdata == (rdPast ^ wdPast));
   endproperty
   a_xorOp: assert property (p_xorOp) else $error("xor result wrong"); // [RULE_25]

   property p_pass;
      @(posedge core_clk) disable iff (rst)
      (!inRead && !dec.hit) |-> (slvReq == mstReq) && (mstReady == slvReady);
   endproperty
   a_pass: assert property (p_pass) else $error("plain transfer altered"); // [RULE_03]

   property p_waits;
      @(posedge core_clk) disable iff (rst)
      (inWrite && !slvReady) |-> !mstReady ##1 (inWrite && $stable(slvWdata));
   endproperty
   a_waits: assert property (p_waits) else $error("wait state not passed back"); // [RULE_15]

   property p_nonCore;
      @(posedge core_clk) disable iff (rst)
      (!inRead && mstMasterId != CORE_MASTER_ID) |-> (slvReq.haddr == mstReq.haddr);
   endproperty
   a_nonCore: assert property (p_nonCore) else $error("other master decorated"); // [RULE_01]

   property p_base;
      @(posedge core_clk) disable iff (rst)
      decStart |-> (slvReq.haddr[31:29] == ((mstReq.haddr[30:29] == 2'h1) ? 3'h1 : 3'h2));
   endproperty
   a_base: assert property (p_base) else $error("wrong target base"); // [RULE_18]

   // ======================================================
   // hold, size and hand-back checks
   sequence s_writeAddr;
      slvReq.hwrite && slvReq.hmastlock && (slvReq.htrans == HTRANS_NSEQ);
   endsequence

   sequence s_backToPass;
      !inRead && !inWrite;
   endsequence

   // a wait in the read phase must not let any other transfer slip in
   property p_holdWrite;
      @(posedge core_clk) disable iff (rst)
      (inRead && !slvReady) |=> s_writeAddr ##0 (inRead && $stable(slvReq.haddr));
   endproperty
   a_holdWrite: assert property (p_holdWrite) else $error("write phase not held under wait"); // [RULE_26]

   property p_size;
      @(posedge core_clk) disable iff (rst)
      s_start |-> (slvReq.hsize == mstReq.hsize);
   endproperty
   a_size: assert property (p_size) else $error("read size differs from store size"); // [RULE_16]

   // capture must keep the stripped address, not the decorated one
   property p_capture;
      @(posedge core_clk) disable iff (rst)
      s_start |=> (capReg.haddr == $past(slvReq.haddr)) && (funcReg == $past(dec.func));
   endproperty
   a_capture: assert property (p_capture) else $error("captured address or function wrong"); // [RULE_11]

   // peripheral targets stay inside the plain peripheral megabyte
   property p_periSpan;
      @(posedge core_clk) disable iff (rst)
      (decStart && slvReq.haddr[30]) |-> (slvReq.haddr[31:20] == 12'h400);
   endproperty
   a_periSpan: assert property (p_periSpan) else $error("peripheral target out of span"); // [RULE_06]

   property p_readyWrite;
      @(posedge core_clk) disable iff (rst)
      inWrite |-> (mstReady == slvReady) && (mstResp == slvResp);
   endproperty
   a_readyWrite: assert property (p_readyWrite) else $error("write phase answer not passed back"); // [RULE_15]

   // a locked pair ends by handing the bus back or by starting the next pair
   property p_done;
      @(posedge core_clk) disable iff (rst)
      (inWrite && slvReady && !decStart) |=> s_backToPass;
   endproperty
   a_done: assert property (p_done) else $error("sequence did not return to plain"); // [RULE_10]

   // loads are never decorated; only stores turn into pairs
   property p_loadPlain;
      @(posedge core_clk) disable iff (rst)
      (!inRead && !mstReq.hwrite) |-> (slvReq == mstReq);
   endproperty
   a_loadPlain: assert property (p_loadPlain) else $error("load was altered"); // [RULE_08]

   // no new write data shown while the read phase waits
   property p_quiet;
      @(posedge core_clk) disable iff (rst)
      (inRead && !slvReady) |=> $stable(slvWdata);
   endproperty
   a_quiet: assert property (p_quiet) else $error("write data toggled in read wait"); // [RULE_22]

   // an error on the read is hidden; the write still goes out
   property p_hideErr;
      @(posedge core_clk) disable iff (rst)
      inRead |-> (mstResp == HRESP_OKAY);
   endproperty
   a_hideErr: assert property (p_hideErr) else $error("response shown during read phase"); // [RULE_13]

endmodule

// *** bench/ars_slave_model.sv ***
// slave memory model on the decorator's output bus
`timescale 1ns/1ps
module ars_slave_model
   import ars_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire ars_req_s    slvReq,
   input  wire logic [31:0] slvWdata,
   input  wire logic [3:0]  waitCount,
   output      logic [31:0] slvRdata,
   output      logic        slvReady,
   output      logic        slvResp
);
   // ======================================
   // data phase tracking
   logic [31:0] mem [0:15];
   logic [31:0] dpAddr;
   logic [31:0] noise;
   logic        dpValid;
   logic        dpWrite;
   logic [3:0]  waitLeft;
   logic [2:0]  dpSize;
   // byte lanes that a write of this size and address really touches
   wire  [3:0]  laneSel = (dpSize == 3'h0) ? (4'h1 << dpAddr[1:0])
                        : ((dpSize == 3'h1) ? (dpAddr[1] ? 4'hC : 4'h3) : 4'hF);

   // read data valid only as a read phase ends; noise exposes early sampling
   assign slvRdata = (dpValid && !dpWrite && slvReady) ? mem[dpAddr[5:2]] : noise;
   assign slvReady = (waitLeft == 4'h0);
   assign slvResp  = HRESP_OKAY;

   // waits run down before a data phase may end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dpValid  <= 1'b0;
         dpWrite  <= 1'b0;
         dpAddr   <= 32'h0;
         waitLeft <= 4'h0;
         dpSize   <= 3'h0;
         noise    <= 32'h0;
      end else begin
         noise <= ~noise + 32'h1357_9BDF;
         if (!slvReady) begin
            waitLeft <= waitLeft - 4'h1;
         end else begin
            if (dpValid && dpWrite) begin
               for (int b = 0; b < 4; b++) begin
                  if (laneSel[b]) begin
                     mem[dpAddr[5:2]][8*b +: 8] <= slvWdata[8*b +: 8];
                  end
               end
            end
            dpValid  <= slvReq.htrans[1];
            dpSize   <= slvReq.hsize;
            dpAddr   <= slvReq.haddr;
            dpWrite  <= slvReq.hwrite;
            waitLeft <= slvReq.htrans[1] ? waitCount : 4'h0;
         end
      end
   end
endmodule

// *** bench/atomic_rmw_store_decorator_bench.sv ***
// self-checking bench for the atomic store decorator
`timescale 1ns/1ps
module atomic_rmw_store_decorator_bench
   import ars_pkg::*;
;
   // ======================================
   // clock, reset and wiring
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   ars_req_s    mstReq = REQ_RST;
   logic [31:0] mstWdata = DATA_RST;
   logic [3:0]  mstMasterId = 4'h3;
   logic [3:0]  waitCount = 4'h0;
   logic [31:0] mstRdata, slvWdata, slvRdata, rd;
   logic        mstReady, mstResp, slvReady, slvResp, resp;
   ars_req_s    slvReq;
   ars_req_s    seen[$];
   int          err_count = 0;
   int          checks_done = 0;
   int          stall;

   always #20 core_clk = ~core_clk;

   ars_decorator #(.CORE_MASTER_ID(4'h3)) i_dut (.core_clk(core_clk), .rst(rst), .mstReq(mstReq),
      .mstWdata(mstWdata), .mstMasterId(mstMasterId), .mstRdata(mstRdata), .mstReady(mstReady),
      .mstResp(mstResp), .slvReq(slvReq), .slvWdata(slvWdata), .slvRdata(slvRdata),
      .slvReady(slvReady), .slvResp(slvResp));
   ars_slave_model i_slv (.core_clk(core_clk), .rst(rst), .slvReq(slvReq), .slvWdata(slvWdata),
      .waitCount(waitCount), .slvRdata(slvRdata), .slvReady(slvReady), .slvResp(slvResp));

   // log accepted address phases; negedge keeps clear of the edge race
   always @(negedge core_clk) begin
      if (slvReady && slvReq.htrans[1]) begin
         seen.push_back(slvReq);
      end
   end

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one transfer; request held until accepted, stall counts ready-low data cycles
   task automatic xfer(input logic [31:0] a, input logic wr, input logic [2:0] sz, input logic [31:0] wd);
      int n;
      mstReq.haddr = a;
      mstReq.htrans = HTRANS_NSEQ;
      mstReq.hwrite = wr;
      mstReq.hsize = sz;
      n = 0;
      @(negedge core_clk);
      while (mstReady !== 1'b1 && n < 100) begin
         n++;
         @(negedge core_clk);
      end
      @(posedge core_clk);
      #1;
      mstReq.htrans = HTRANS_IDLE;
      mstWdata = wd;
      stall = 0;
      @(negedge core_clk);
      while (mstReady !== 1'b1 && stall < 100) begin
         stall++;
         @(negedge core_clk);
      end
      rd = mstRdata;
      resp = mstResp;
      @(posedge core_clk);
      #1;
      chk("xfer limit", {31'h0, (n < 100) && (stall < 100)}, 32'h1);
   endtask

   // plain and look-alike accesses pass unchanged, no extra cycles
   task automatic t_plain();
      logic [31:0] a [5] = '{32'h2000_0008, 32'hA400_0008, 32'h2200_0008, 32'h2400_0008, 32'h6400_0008};
      for (int i = 0; i < 5; i++) begin
         mstMasterId = (i == 3) ? 4'h5 : 4'h3;
         seen.delete();
         xfer(a[i], 1'b1, 3'h2, 32'h1111_0000 + i);
         chk("plain count", seen.size(), 1);
         chk("plain addr", seen[0].haddr, a[i]);
         chk("plain stall", stall, 0);
         xfer(a[i], 1'b0, 3'h2, 32'h0);
         chk("plain read", rd, 32'h1111_0000 + i);
      end
      mstMasterId = 4'h3;
      $display("test plain done");
   endtask

   // one decorated store checked phase by phase
   task automatic t_rmw(input logic [2:0] fn, input logic [1:0] tg, input logic [2:0] sz,
                        input logic [3:0] w, input logic [19:0] off);
      logic [31:0] act, wa, m, op, exp;
      logic [31:0] wd = 32'h5A5A_5A5A;
      act = ((tg == TARGET_RAM) ? RAM_BASE : PERI_BASE) + {12'h0, off};
      // word-aligned plain accesses; only the lanes of the store size change
      wa = {act[31:2], 2'h0};
      m = (sz == 3'h0) ? (32'h0000_00FF << (8 * off[1:0]))
        : ((sz == 3'h1) ? (32'h0000_FFFF << (16 * off[1])) : 32'hFFFF_FFFF);
      waitCount = 4'h0;
      xfer(wa, 1'b1, 3'h2, 32'h0FF0_C3A5);
      op = (fn == FUNC_AND) ? (32'h0FF0_C3A5 & wd) : (fn == FUNC_OR) ? (32'h0FF0_C3A5 | wd)
         : (32'h0FF0_C3A5 ^ wd);
      exp = (32'h0FF0_C3A5 & ~m) | (op & m);
      seen.delete();
      waitCount = w;
      xfer({1'b0, tg, fn, 6'h3F, off}, 1'b1, sz, wd);
      chk("rmw phases", seen.size(), 2);
      chk("read addr", seen[0].haddr, act);
      chk("read kind", {31'h0, seen[0].hwrite}, 32'h0);
      chk("write addr", seen[1].haddr, act);
      chk("write attrs", {28'h0, seen[1].hwrite, seen[1].hsize}, {28'h0, 1'b1, sz});
      chk("lock", {30'h0, seen[0].hmastlock, seen[1].hmastlock}, 32'h3);
      chk("stall cycles", stall, 2 * w + 1);
      chk("resp", {31'h0, resp}, {31'h0, HRESP_OKAY});
      waitCount = 4'h0;
      xfer(wa, 1'b0, 3'h2, 32'h0);
      chk("result", rd, exp);
      $display("test rmw fn %0d target %0d done", fn, tg);
   endtask

   // reset in the middle of a locked pair drops it and leaves plain passing
   task automatic t_reset();
      mstReq.haddr = {1'b0, TARGET_RAM, FUNC_AND, 6'h00, 20'h0_0030};
      mstReq.htrans = HTRANS_NSEQ;
      mstReq.hwrite = 1'b1;
      mstReq.hsize = 3'h2;
      @(posedge core_clk);
      #1;
      mstReq.htrans = HTRANS_IDLE;
      chk("reset stall", {31'h0, mstReady}, 32'h0);
      rst = 1'b1;
      #1;
      chk("reset pass", {31'h0, mstReady}, 32'h1);
      repeat (2) @(posedge core_clk);
      #1;
      rst = 1'b0;
      seen.delete();
      xfer(32'h2000_0030, 1'b0, 3'h2, 32'h0);
      chk("after reset", seen.size(), 1);
      $display("test reset done");
   endtask

   initial begin
      repeat (12) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_plain();
      t_rmw(FUNC_AND, TARGET_RAM, 3'h2, 4'h0, 20'h0_0014);
      t_rmw(FUNC_OR, TARGET_PERI, 3'h1, 4'h2, 20'h0_0016);
      t_rmw(FUNC_XOR, TARGET_RAM, 3'h0, 4'h1, 20'h0_0024);
      t_rmw(FUNC_AND, TARGET_PERI, 3'h0, 4'h1, 20'hF_F013);
      t_rmw(FUNC_XOR, TARGET_PERI, 3'h2, 4'h3, 20'h7_FFFC);
      t_rmw(FUNC_OR, TARGET_RAM, 3'h2, 4'h0, 20'h0_0038);
      t_reset();
      end_of_test();
   end

   // watchdog well beyond the expected run length
   initial begin
      #200000;
      err_count++;
      end_of_test();
   end
endmodule
